// ---- inc/port_b_regs.vh ----
`ifndef PORT_B_REGS_VH
`define PORT_B_REGS_VH

// Port width and field positions.
`define PB_WIDTH        8
`define PB_ANALOG_LSB   0
`define PB_ANALOG_MSB   4
`define PB_ANALOG_W     5
`define PB_BIT_EXT_IRQ_2     2
`define PB_BIT_EXT_IRQ_3     3
`define PB_BIT_DBG_CLK  6
`define PB_BIT_DBG_DATA 7

// Reset values, strap choices and the PWM mask.
`define PB_DIR_RESET    8'hff
`define PB_LATCH_RESET  8'h00
`define PB_PWM_MASK     8'hf3
`define PB_ANALOG_ALL   5'h1f
`define PB_ANALOG_NONE  5'h00

`endif

// ---- rtl/schmitt_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage hysteresis model: the output changes only after two equal
// samples, standing in for a Schmitt-trigger input buffer.
module schmitt_sync (
    // Clock and reset.
    input  wire clk,
    input  wire rst,
    // Raw pin sample and filtered level.
    input  wire din,
    output wire dout
);

    reg stage_reg;
    reg level_reg;

    // The level follows only a stable sample, so a single-cycle glitch is dropped.
    always @(posedge clk) begin
        if (rst) begin
            stage_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            stage_reg <= din;
            if (stage_reg == din) begin
                level_reg <= din;
            end
        end
    end

    assign dout = level_reg;

endmodule

`default_nettype wire

// ---- rtl/port_b_pin_function_mux.v ----
// Summary of operation
// [RULE1] Output pin drives latch bit when direction 0.
// [RULE2] Input pin reads level; pull-up when enabled.
// [RULE3] Analog bits 0-4 block digital input, pull-up.
// [RULE4] PWM 0-5 to bits 0,1,4,5,6,7 outputs.
// [RULE5] Bits 2,3 feed interrupt and change inputs.
// [RULE6] Bits 2,3 carry timer1 and comparator signals.
// [RULE7] Bit 6 debug clock, bit 7 debug data.
// [RULE8] Power-on analog default follows configuration bit.
// [RULE9] Pull-ups off on outputs and after reset.
// [RULE10] Enabled peripheral output overrides latch bit.
`timescale 1ns/1ps
`default_nettype none
`include "port_b_regs.vh"

module port_b_pin_function_mux (
    // Clock and reset.
    input  wire       clk,
    input  wire       rst,
    // Software register writes.
    input  wire       direction_we,
    input  wire [7:0] direction_wdata,
    input  wire       latch_we,
    input  wire [7:0] latch_wdata,
    input  wire       pullup_we,
    input  wire       pullup_wdata_n,
    input  wire       analog_sel_we,
    input  wire [4:0] analog_sel_wdata,
    // Configuration strap.
    input  wire       analog_default_cfg,
    // Register read-back.
    output wire [7:0] direction_reg,
    output wire [7:0] output_latch,
    output wire [7:0] pin_read_reg,
    output wire       pullup_disable_n,
    output wire [4:0] analog_sel,
    // PWM alternate outputs.
    input  wire [5:0] pwm_out,
    input  wire [5:0] pwm_enable,
    // Timer1 oscillator.
    input  wire       timer1_osc_enable,
    input  wire       timer1_osc_out,
    output wire       timer1_clk_in,
    output wire       timer1_osc_in,
    // Comparator and interrupt feeds.
    output wire       comparator1_in,
    output wire       comparator2_in,
    output wire       ext_irq_2,
    output wire       ext_irq_3,
    output wire       change_in_2,
    output wire       change_in_3,
    // Debugger.
    input  wire       debug_enable,
    input  wire       debug_data_out,
    input  wire       debug_data_drive,
    output wire       debug_clock_pin,
    output wire       debug_data_pin,
    // Pads: oe_n low means the pad is driven.
    input  wire [7:0] pad_in,
    output wire [7:0] pad_out,
    output wire [7:0] pad_oe_n,
    output wire [7:0] pad_pullup_en,
    output wire [7:0] pad_analog_en
);

    // Software-visible state. The direction register resets to all inputs so
    // that only the oscillator on bit 2 and the debugger on bit 7 can drive a pad
    // before software has chosen a direction, and the analog selection resets
    // to none until the strap is caught.
    reg  [7:0] direction_reg_r;
    reg  [7:0] latch_reg;
    reg        pullup_n_reg;
    reg  [4:0] analog_reg;
    reg        por_done_reg;
    reg  [7:0] pin_read_q_reg;
    reg  [7:0] out_next;
    reg  [7:0] drive_next;
    wire [7:0] analog_mask;
    wire [7:0] in_enable;
    wire [7:0] pwm_map;
    wire [7:0] pwm_en_map;
    wire       st_bit2;
    wire       st_bit3;
    wire       st_bit6;

    // Registers; the strap is caught on the first clock after reset release.
    // The strap load takes priority over a software write to the analog
    // selection in that one cycle, so the power-on default always lands first.
    // Other registers accept writes from that same cycle on.
    always @(posedge clk) begin
        if (rst) begin
            direction_reg_r <= `PB_DIR_RESET;
            latch_reg       <= `PB_LATCH_RESET;
            pullup_n_reg    <= 1'b1; // RULE9
            analog_reg      <= `PB_ANALOG_NONE;
            por_done_reg    <= 1'b0;
        end else begin
            por_done_reg <= 1'b1;
            if (!por_done_reg) begin
                analog_reg <= analog_default_cfg ? `PB_ANALOG_ALL : `PB_ANALOG_NONE; // RULE8
            end else if (analog_sel_we) begin
                analog_reg <= analog_sel_wdata;
            end
            if (direction_we) begin
                direction_reg_r <= direction_wdata;
            end
            if (latch_we) begin
                latch_reg <= latch_wdata;
            end
            if (pullup_we) begin
                pullup_n_reg <= pullup_wdata_n;
            end
        end
    end

    // Only bits 0 to 4 have an analog option.
    // An analog pin loses its digital input path and its pull-up, while its
    // output driver is left to the direction bit and, on bit 2, the oscillator override.
    assign analog_mask = {3'b000, analog_reg}; // RULE3
    assign in_enable   = direction_reg_r & ~analog_mask; // RULE3

    // PWM channel placement on the port bits.
    // Bits 2 and 3 carry no PWM channel, so their enable slots are forced to
    // zero here and again by the mask.
    assign pwm_map    = {pwm_out[5], pwm_out[4], pwm_out[3], pwm_out[2],
                         2'b00, pwm_out[1], pwm_out[0]}; // RULE4
    assign pwm_en_map = {pwm_enable[5], pwm_enable[4], pwm_enable[3], pwm_enable[2],
                         2'b00, pwm_enable[1], pwm_enable[0]} & `PB_PWM_MASK; // RULE4

    // Output select: peripheral over latch; debugger data owns bit 7 when driving.
    // The latch is the default source; an enabled PWM channel replaces it bit
    // by bit. The oscillator then claims bit 2 and the debugger claims bits 6
    // and 7, so the order of the statements below sets the priority.
    always @* begin
        out_next   = latch_reg; // RULE1
        drive_next = ~direction_reg_r; // RULE1
        out_next   = (out_next & ~pwm_en_map) | (pwm_map & pwm_en_map); // RULE10
        if (timer1_osc_enable) begin
            out_next[`PB_BIT_EXT_IRQ_2]   = timer1_osc_out; // RULE6
            drive_next[`PB_BIT_EXT_IRQ_2] = 1'b1;
        end
        if (debug_enable) begin
            out_next[`PB_BIT_DBG_DATA]   = debug_data_out; // RULE7
            drive_next[`PB_BIT_DBG_DATA] = debug_data_drive;
            drive_next[`PB_BIT_DBG_CLK]  = 1'b0;
        end
    end

    // A PWM channel can only reach a pad whose direction bit is 0, since the
    // drive term starts from the inverted direction register. The debugger and
    // oscillator overrides are applied after that term, so they keep their
    // pads even when a PWM enable points at the same bit.
    assign pad_out  = out_next;
    assign pad_oe_n = ~drive_next; // RULE4

    // Pull-ups only on digital inputs with the global enable cleared.
    // Using the final drive term means a pad driven by the oscillator or by the
    // debugger data output loses its pull-up; the debug clock pad keeps its own.
    assign pad_pullup_en = {8{~pullup_n_reg}} & in_enable & ~drive_next; // RULE9
    assign pad_analog_en = analog_mask;

    // Pin read: disabled inputs read zero; registered to give a clean sample.
    // The one-cycle delay is the price of a glitch-free read-back; software
    // polling the port sees a pad change one clock late.
    always @(posedge clk) begin
        if (rst) begin
            pin_read_q_reg <= 8'h00;
        end else begin
            pin_read_q_reg <= pad_in & in_enable; // RULE2
        end
    end

    // Schmitt-trigger inputs for interrupt, timer clock and debug clock.
    // Each filtered path adds two cycles of latency, which limits the
    // fastest edge rate these feeds can follow to a few clocks per level.
    schmitt_sync u_st2 (
        .clk  (clk),
        .rst  (rst),
        .din  (pad_in[`PB_BIT_EXT_IRQ_2] & in_enable[`PB_BIT_EXT_IRQ_2]),
        .dout (st_bit2)
    );
    schmitt_sync u_st3 (
        .clk  (clk),
        .rst  (rst),
        .din  (pad_in[`PB_BIT_EXT_IRQ_3] & in_enable[`PB_BIT_EXT_IRQ_3]),
        .dout (st_bit3)
    );
    schmitt_sync u_st6 (
        .clk  (clk),
        .rst  (rst),
        .din  (pad_in[`PB_BIT_DBG_CLK]),
        .dout (st_bit6)
    );

    // Interrupt and change feeds require the pin to be an input.
    assign ext_irq_2   = st_bit2; // RULE5
    assign ext_irq_3   = st_bit3; // RULE5
    assign change_in_2 = pin_read_q_reg[`PB_BIT_EXT_IRQ_2]; // RULE5
    assign change_in_3 = pin_read_q_reg[`PB_BIT_EXT_IRQ_3]; // RULE5

    // Analog comparator and oscillator inputs are taken straight from the pad.
    // They bypass the digital gating on purpose: an analog pin must still reach
    // the comparator while its digital input path is switched off.
    assign comparator2_in = pad_in[`PB_BIT_EXT_IRQ_2]; // RULE6
    assign comparator1_in = pad_in[`PB_BIT_EXT_IRQ_3]; // RULE6
    assign timer1_osc_in  = pad_in[`PB_BIT_EXT_IRQ_3]; // RULE6
    assign timer1_clk_in  = st_bit2; // RULE6

    // Debugger sees its clock through hysteresis and the raw data pin.
    // Both feeds read zero while the debugger is off, so a stray edge on a
    // shared pin cannot reach it during normal use.
    assign debug_clock_pin = debug_enable & st_bit6; // RULE7
    assign debug_data_pin  = debug_enable & pad_in[`PB_BIT_DBG_DATA]; // RULE7

    // Register read-back to software. These are plain copies of the state, so
    // a read never disturbs anything.
    assign direction_reg    = direction_reg_r;
    assign output_latch     = latch_reg;
    assign pin_read_reg     = pin_read_q_reg;
    assign pullup_disable_n = pullup_n_reg;
    assign analog_sel       = analog_reg;

endmodule

`default_nettype wire

// ---- tb/port_b_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Ties pad drive, pull-ups and read-back to the registers and the strap.
module port_b_checker (
    input wire logic       clk, rst, pullup_disable_n, analog_default_cfg, timer1_osc_enable,
    input wire logic       timer1_osc_out, debug_enable, comparator1_in, comparator2_in,
    input wire logic       timer1_osc_in,
    input wire logic [4:0] analog_sel,
    input wire logic [5:0] pwm_out, pwm_enable,
    input wire logic [7:0] direction_reg, output_latch, pin_read_reg, pad_in, pad_out,
    input wire logic [7:0] pad_oe_n, pad_pullup_en
);
    // PWM channels spread onto bits 0, 1 and 4 to 7; dig8 marks digital inputs.
    wire [7:0] en8   = {pwm_enable[5:2], 2'h0, pwm_enable[1:0]};
    wire [7:0] pwm8  = {pwm_out[5:2], 2'h0, pwm_out[1:0]};
    wire [7:0] dig8  = direction_reg & ~{3'h0, analog_sel};
    wire       quiet = !timer1_osc_enable && !debug_enable;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_DRIVE_VALUE: assert property (quiet |->
        ((pad_out ^ (en8 & pwm8 | ~en8 & output_latch)) & ~direction_reg) == 8'h00)
        else $error("pad value wrong");
    AST_DRIVE_ENABLE: assert property (quiet |-> pad_oe_n == direction_reg)
        else $error("pad enable wrong");
    AST_OSC_DRIVE: assert property (timer1_osc_enable |->
        !pad_oe_n[2] && pad_out[2] == timer1_osc_out) else $error("oscillator drive wrong");
    AST_PIN_READ: assert property (1'b1 |=>
        pin_read_reg == ($past(pad_in) & $past(dig8))) else $error("read-back wrong");
    AST_PULLUP: assert property (pad_pullup_en ==
        ({8{~pullup_disable_n}} & dig8 & pad_oe_n)) else $error("pull-up wrong");
    AST_STRAP: assert property ($fell(rst) |=>
        analog_sel == ($past(analog_default_cfg) ? 5'h1f : 5'h00)) else $error("strap wrong");
    AST_RESET_STATE: assert property ($fell(rst) |->
        direction_reg == 8'hff && output_latch == 8'h00 && pullup_disable_n)
        else $error("reset state wrong");
    AST_ANALOG_FEED: assert property (comparator2_in == pad_in[2] &&
        comparator1_in == pad_in[3] && timer1_osc_in == pad_in[3]) else $error("feed wrong");
endmodule
bind port_b_pin_function_mux port_b_checker chk (.*);
`default_nettype wire

// ---- tb/board_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_pins (
    // Clock and block pad side.
    input  wire logic       clk,
    input  wire logic [7:0] pad_out, pad_oe_n, pad_pullup_en,
    // Board drivers.
    input  wire logic [7:0] ext_drive, ext_val,
    output wire logic [7:0] pad_in
);
    logic [7:0] float_reg = 8'h00;
    // A floating pad toggles so that it never passes for a steady level.
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    // Block drive first, then the board, then the weak pull-up.
    assign pad_in = ~pad_oe_n & pad_out |
        pad_oe_n & (ext_drive & ext_val | ~ext_drive & (pad_pullup_en | float_reg));
endmodule
`default_nettype wire

// ---- tb/port_b_pin_function_mux_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_b_pin_function_mux_bench;
    // Block inputs and board drivers.
    logic       clk = 1'b0, rst = 1'b1, direction_we = 1'b0, latch_we = 1'b0, pullup_we = 1'b0;
    logic       analog_sel_we = 1'b0, pullup_wdata_n = 1'b1, analog_default_cfg = 1'b1;
    logic       timer1_osc_enable = 1'b0, timer1_osc_out = 1'b0, debug_enable = 1'b0;
    logic       debug_data_out = 1'b0, debug_data_drive = 1'b0;
    logic [4:0] analog_sel_wdata = 5'h00;
    logic [5:0] pwm_out = 6'h00, pwm_enable = 6'h00;
    logic [7:0] direction_wdata = 8'h00, latch_wdata = 8'h00, ext_val = 8'h00, ext_drive = 8'hff;
    logic [7:0] dg, rd, ed;
    integer     err_count = 0, n_tests = 0, seed = 32'h92d8, i, k;
    // Block outputs.
    wire  [7:0] direction_reg, output_latch, pin_read_reg, pad_in, pad_out, pad_oe_n;
    wire  [7:0] pad_pullup_en, pad_analog_en;
    wire  [4:0] analog_sel;
    wire        pullup_disable_n, timer1_clk_in, timer1_osc_in, comparator1_in, comparator2_in;
    wire        ext_irq_2, ext_irq_3, change_in_2, change_in_3, debug_clock_pin, debug_data_pin;

    port_b_pin_function_mux uut (.*);
    board_pins board (.*);

    // Clock at 25 MHz.
    always #20 clk = ~clk;

    // Expected pad value on output pins: enabled PWM channels win over the latch.
    function logic [7:0] exp_drive(input logic [7:0] l, input logic [5:0] p, input logic [5:0] e);
        exp_drive = {e[5:2], 2'h0, e[1:0]} & {p[5:2], 2'h0, p[1:0]} | ~{e[5:2], 2'h0, e[1:0]} & l;
    endfunction

    task check(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, want);
        end
    endtask

    task final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Raise reset on an edge and drop it on the next; at the start it has been
    // high since time zero, so it covers two edges. Then look after the strap load.
    task do_reset(input logic c);
        @(posedge clk);
        rst <= 1'b1;
        analog_default_cfg <= c;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(direction_reg, 8'hff);
        check({7'h0, pullup_disable_n}, 8'h01);
        check({3'h0, analog_sel}, c ? 8'h1f : 8'h00);
    endtask

    // Random configurations; the first of each pass floats all inputs on pull-ups.
    initial begin
        for (k = 0; k < 2; k++) begin
            do_reset(k[0] == 1'b0);
            for (i = 0; i < 60; i++) begin
                @(posedge clk);
                {direction_we, latch_we, pullup_we, analog_sel_we} <= 4'hf;
                direction_wdata <= (i == 0) ? 8'hff : 8'($random(seed));
                pullup_wdata_n <= (i == 0) ? 1'b0 : 1'($random(seed));
                analog_sel_wdata <= (i == 0) ? 5'h00 : 5'($random(seed));
                ext_drive <= (i == 0) ? 8'h00 : 8'hff;
                latch_wdata <= 8'($random(seed));
                pwm_out <= 6'($random(seed));
                pwm_enable <= 6'($random(seed));
                ext_val <= 8'($random(seed));
                @(posedge clk);
                {direction_we, latch_we, pullup_we, analog_sel_we} <= 4'h0;
                repeat (5) @(posedge clk);
                #1;
                dg = direction_wdata & ~{3'h0, analog_sel_wdata};
                rd = (ext_val | ~ext_drive) & dg;
                check(pad_oe_n, direction_wdata);
                ed = exp_drive(latch_wdata, pwm_out, pwm_enable) & ~direction_wdata;
                check(pad_out & ~direction_wdata, ed);
                check(pad_pullup_en, ~{8{pullup_wdata_n}} & dg);
                check(pin_read_reg, rd);
                check({6'h0, ext_irq_3, ext_irq_2}, {6'h0, rd[3:2]});
                check({6'h0, change_in_3, change_in_2}, {6'h0, rd[3:2]});
                check({7'h0, timer1_clk_in}, {7'h0, rd[2]});
                check(pad_analog_en, {3'h0, analog_sel_wdata});
                check(output_latch, latch_wdata);
                check({7'h0, debug_data_pin}, 8'h00);
            end
        end
        // Oscillator and debugger take their pins over; debugger data drives 0.
        @(posedge clk);
        {timer1_osc_enable, debug_enable, debug_data_drive, timer1_osc_out} <= 4'hf;
        ext_val <= 8'h40;
        repeat (5) @(posedge clk);
        #1;
        check({3'h0, pad_oe_n[7:6], pad_oe_n[2], pad_out[7], pad_out[2]}, 8'h09);
        check({6'h0, debug_clock_pin, debug_data_pin}, 8'h02);
        // A released data pin follows the board; the clock pin falls through the filter.
        @(posedge clk);
        debug_data_drive <= 1'b0;
        ext_val <= 8'h80;
        repeat (5) @(posedge clk);
        #1;
        check({6'h0, pad_oe_n[7], debug_data_pin}, 8'h03);
        check({7'h0, debug_clock_pin}, 8'h00);
        final_report;
    end

    // Watchdog: the run needs about 900 cycles, so 100 us means a hang.
    initial begin
        #100000;
        err_count++;
        final_report;
    end
endmodule
`default_nettype wire
